// ---- rmsc_regs.svh ----
// Constants of the reversing motor switch control: offsets, fields, resets, timing.
// Assumes a 25 MHz hclk and one AHB-Lite master doing single word transfers.
//
// Behaviour
// (R01) Reverse rotation by swapping two phases only; third phase passes straight.
// (R02) Never drive both directions; an active request blocks the other one.
// (R03) Reversal holds both sets off 20 ms, or 100 ms with dead time bridge.
// (R04) Supervise current on the first phase only against the user threshold.
// (R05) With supply present and no fault latched, monitoring relay is enabled.
// (R06) Start only on a rising command edge, never on an old level.
// (R07) Start-up delay 0.1 to 5 s ignores overcurrent; trip if still over after.
// (R08) Overcurrent while running after start-up starts the switching delay timer.
// (R09) Still over threshold when switching delay ends drops the relay to fault.
// (R10) Overcurrent fault stays latched until the run command is removed.
// (R11) With function bridge an overcurrent trip also switches the motor off.
// (R12) Overtemperature switches semiconductors off, drops relay, and latches.
// (R13) Overtemperature clears only after cooling and a control supply cycle.
// (R14) Power lamp steady with supply, flashing while start-up delay runs.
// (R15) Direction lamps show active clockwise or anticlockwise drive.
// (R16) Overcurrent lamp flashes while the switching delay counts down.
// (R17) Current with switches off is a system fault: red lamps flash, starts refused.
// (R18) Release within 10 ms (low voltage) or 60 ms of command removal.
// (R19) Switch on within 10 ms (low voltage) or 15 ms of command assertion.
// (R20) Range bridge selects one of two current threshold ranges.
`ifndef RMSC_REGS_SVH
`define RMSC_REGS_SVH

// ============================================================
// Register offsets
`define RMSC_CTRL_OFS      8'h00
`define RMSC_STARTUP_OFS   8'h04
`define RMSC_TRIP_OFS      8'h08
`define RMSC_THRESH_OFS    8'h0C
`define RMSC_STATUS_OFS    8'h10

// ============================================================
// Fields and reset values
`define RMSC_CTRL_FUNC     0
`define RMSC_CTRL_DEAD     1
`define RMSC_CTRL_RANGE    2
`define RMSC_CTRL_RST      3'h0
`define RMSC_DLY_RST       6'h0A
`define RMSC_DLY_MIN       6'h01
`define RMSC_DLY_MAX       6'h32
`define RMSC_THRESH_RST    8'h80

// ============================================================
// Timing
`define RMSC_CLK_KHZ       25000
`define RMSC_DEAD_SHORT_MS 20
`define RMSC_DEAD_LONG_MS  100
`define RMSC_TICK_MS       100
`define RMSC_FLASH_MS      250
`define RMSC_SETTLE_MS     20

`endif

// ---- rmsc_pkg.sv ----
// Types of the reversing motor switch control.
// Field widths of the state record are written out here and must match rmsc_regs.svh.
package rmsc_pkg;

   // ============================================================
   // Drive sequencer states
   typedef enum logic [3:0] {
      RMSC_IDLE = 4'h1,
      RMSC_GAP  = 4'h2,
      RMSC_RUN  = 4'h4,
      RMSC_HALT = 4'h8
   } rmsc_fsm_t;

   // ============================================================
   // Whole state of the block
   typedef struct packed {
      rmsc_fsm_t   state;
      logic        cw_q;
      logic        ccw_q;
      logic        dir;
      logic [22:0] off_cnt;
      logic [22:0] pre_cnt;
      logic [5:0]  dly_cnt;
      logic        blanking;
      logic        timing;
      logic        oc_latch;
      logic        ot_latch;
      logic        sys_fault;
      logic [22:0] flash_cnt;
      logic        flash;
      logic [2:0]  ctrl;
      logic [5:0]  startup;
      logic [5:0]  trip;
      logic [7:0]  thresh;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        sw_straight;
      logic        sw_swap;
      logic        sw_third;
      logic        relay_enable;
      logic        lamp_power;
      logic        lamp_cw;
      logic        lamp_ccw;
      logic        lamp_overcur;
      logic        lamp_overtemp;
   } rmsc_regs_t;

endpackage : rmsc_pkg

// ---- rmsc_top.sv ----
// Reversing motor switch control: drive sequencer, current supervision, lamps.
// Assumes synchronous command and comparator inputs and an AHB-Lite master.
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "rmsc_regs.svh"

module rmsc_top
   import rmsc_pkg::*;
#(
   parameter int unsigned TICK_CYC   = `RMSC_TICK_MS * `RMSC_CLK_KHZ,
   parameter int unsigned DEAD_S_CYC = `RMSC_DEAD_SHORT_MS * `RMSC_CLK_KHZ,
   parameter int unsigned DEAD_L_CYC = `RMSC_DEAD_LONG_MS * `RMSC_CLK_KHZ,
   parameter int unsigned FLASH_CYC  = `RMSC_FLASH_MS * `RMSC_CLK_KHZ,
   parameter int unsigned SETTLE_CYC = `RMSC_SETTLE_MS * `RMSC_CLK_KHZ
)(
   // Clock and supply reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Direction commands
   input  wire logic        cmd_cw,
   input  wire logic        cmd_ccw,
   // Sensing flags
   input  wire logic        current_over,
   input  wire logic        current_present,
   input  wire logic        overtemp,
   // Power switches
   output logic             sw_straight,
   output logic             sw_swap,
   output logic             sw_third,
   // Threshold setting
   output logic             range_select_bridge,
   output logic [7:0]       threshold_level,
   // Relay and lamps
   output logic             relay_enable,
   output logic             lamp_power,
   output logic             lamp_cw,
   output logic             lamp_ccw,
   output logic             lamp_overcur,
   output logic             lamp_overtemp
);

   // ============================================================
   // Counts and helpers
   localparam logic [22:0] TICK_LAST  = 23'(TICK_CYC - 1);
   localparam logic [22:0] FLASH_LAST = 23'(FLASH_CYC - 1);
   localparam logic [22:0] DEAD_S     = 23'(DEAD_S_CYC);
   localparam logic [22:0] DEAD_L     = 23'(DEAD_L_CYC);
   localparam logic [22:0] SETTLE     = 23'(SETTLE_CYC);

   // Out-of-range delay settings are pulled into 0.1 .. 5 s
   function automatic logic [5:0] rmsc_clamp(input logic [5:0] v);
      if (v < `RMSC_DLY_MIN) begin
         return `RMSC_DLY_MIN;
      end
      if (v > `RMSC_DLY_MAX) begin
         return `RMSC_DLY_MAX;
      end
      return v;
   endfunction : rmsc_clamp

   function automatic logic [31:0] rmsc_read(
      input rmsc_regs_t s,
      input logic [7:0] a,
      input logic       cur
   );
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         `RMSC_CTRL_OFS: begin
            d[2:0] = s.ctrl;
         end
         `RMSC_STARTUP_OFS: begin
            d[5:0] = s.startup;
         end
         `RMSC_TRIP_OFS: begin
            d[5:0] = s.trip;
         end
         `RMSC_THRESH_OFS: begin
            d[7:0] = s.thresh;
         end
         `RMSC_STATUS_OFS: begin
            d[3:0]  = s.state;
            d[4]    = s.dir;
            d[5]    = s.blanking;
            d[6]    = s.timing;
            d[7]    = s.oc_latch;
            d[8]    = s.ot_latch;
            d[9]    = s.sys_fault;
            d[10]   = s.relay_enable;
            d[11]   = cur;
            d[17:12] = s.dly_cnt;
         end
         default: begin
            d = 32'h0000_0000;
         end
      endcase
      return d;
   endfunction : rmsc_read

   // ============================================================
   // State
   rmsc_regs_t  q;
   rmsc_regs_t  n;
   logic        own_cmd;
   logic        cw_rise;
   logic        ccw_rise;
   logic        start;
   logic        start_dir;
   logic        dead_over;
   logic        go_run;
   logic        tick;
   logic        expire;
   logic        trip_now;
   logic        addr_ok;
   logic        rd_take;
   logic        run_next;

   // ============================================================
   // Next state
   always_comb begin
      n        = q;
      go_run   = 1'b0;
      trip_now = 1'b0;
      own_cmd  = q.dir ? cmd_ccw : cmd_cw;

      // Edges only count while the opposite command is absent
      cw_rise   = cmd_cw & ~q.cw_q & ~cmd_ccw;      // [R02] [R06]
      ccw_rise  = cmd_ccw & ~q.ccw_q & ~cmd_cw;     // [R02] [R06]
      start     = (cw_rise | ccw_rise) & ~q.sys_fault
                  & ~q.ot_latch & ~overtemp;        // [R17] [R13]
      start_dir = ccw_rise;
      n.cw_q    = cmd_cw;
      n.ccw_q   = cmd_ccw;

      dead_over = q.ctrl[`RMSC_CTRL_DEAD] ? (q.off_cnt >= DEAD_L)
                                          : (q.off_cnt >= DEAD_S);   // [R03]

      // Time since the switches last went off
      if (q.sw_third) begin
         n.off_cnt = 23'h000000;
      end else if (q.off_cnt != 23'h7FFFFF) begin
         n.off_cnt = q.off_cnt + 23'h000001;
      end

      // Shared 0.1 s prescaler for start-up and switching delays
      tick   = (q.pre_cnt == TICK_LAST);
      expire = tick & (q.dly_cnt == `RMSC_DLY_MIN);
      n.pre_cnt = tick ? 23'h000000 : q.pre_cnt + 23'h000001;
      if (tick && q.dly_cnt != 6'h00) begin
         n.dly_cnt = q.dly_cnt - 6'h01;
      end

      // Removing the run command releases an overcurrent fault
      if (!own_cmd) begin
         n.oc_latch = 1'b0;                        // [R10]
      end

      case (q.state)
         RMSC_IDLE: begin
            if (start) begin
               n.dir = start_dir;
               if (start_dir == q.dir || dead_over) begin
                  go_run = 1'b1;                   // [R19]
               end else begin
                  n.state = RMSC_GAP;              // [R03]
               end
            end
         end
         RMSC_GAP: begin
            if (!own_cmd || q.sys_fault) begin
               n.state = RMSC_IDLE;
            end else if (dead_over) begin
               go_run = 1'b1;                      // [R03]
            end
         end
         RMSC_RUN: begin
            if (!own_cmd) begin
               // Release at once; a reversal request goes through the gap
               n.state = start ? RMSC_GAP : RMSC_IDLE;       // [R18]
               n.dir   = start ? start_dir : q.dir;
            end else if (q.blanking) begin
               if (expire) begin
                  n.blanking = 1'b0;
                  trip_now   = current_over;       // [R07] [R04]
               end
            end else if (q.timing) begin
               if (!current_over) begin
                  n.timing = 1'b0;
               end else if (expire) begin
                  n.timing = 1'b0;
                  trip_now = 1'b1;                 // [R09]
               end
            end else if (current_over && !q.oc_latch) begin
               n.timing  = 1'b1;                   // [R08]
               n.dly_cnt = rmsc_clamp(q.trip);
               n.pre_cnt = 23'h000000;
            end
         end
         RMSC_HALT: begin
            if (!cmd_cw && !cmd_ccw) begin
               n.state = RMSC_IDLE;
            end
         end
         default: begin
            n.state = RMSC_IDLE;
         end
      endcase

      if (go_run) begin
         n.state    = RMSC_RUN;
         n.blanking = 1'b1;                        // [R07]
         n.timing   = 1'b0;
         n.dly_cnt  = rmsc_clamp(q.startup);
         n.pre_cnt  = 23'h000000;
      end

      if (trip_now) begin
         n.oc_latch = 1'b1;                        // [R09] [R10]
         if (q.ctrl[`RMSC_CTRL_FUNC]) begin
            n.state = RMSC_HALT;                   // [R11]
         end
      end

      // Overtemperature wins over everything and only reset clears it
      if (overtemp) begin
         n.ot_latch = 1'b1;                        // [R12] [R13]
         if (n.state == RMSC_RUN || n.state == RMSC_GAP) begin
            n.state = RMSC_HALT;                   // [R12]
         end
      end

      // Current after the switches have settled off is a system fault
      if (!q.sw_third && q.off_cnt >= SETTLE && current_present) begin
         n.sys_fault = 1'b1;                       // [R17]
      end

      run_next = (n.state == RMSC_RUN);
      if (!run_next) begin
         n.blanking = 1'b0;
         n.timing   = 1'b0;
      end

      // ========================================================
      // Power switches: third phase straight, first two swapped
      n.sw_third    = run_next;                    // [R01]
      n.sw_straight = run_next & ~n.dir;           // [R01] [R02]
      n.sw_swap     = run_next & n.dir;            // [R01] [R02]

      // ========================================================
      // Relay and lamps
      n.relay_enable = ~n.oc_latch & ~n.ot_latch;  // [R05] [R12]
      if (q.flash_cnt == FLASH_LAST) begin
         n.flash_cnt = 23'h000000;
         n.flash     = ~q.flash;
      end else begin
         n.flash_cnt = q.flash_cnt + 23'h000001;
      end
      n.lamp_power = n.blanking ? q.flash : 1'b1;  // [R14]
      n.lamp_cw    = n.sw_straight;                // [R15]
      n.lamp_ccw   = n.sw_swap;                    // [R15]
      if (n.sys_fault) begin
         n.lamp_overcur  = q.flash;                // [R17]
         n.lamp_overtemp = q.flash;                // [R17]
      end else begin
         n.lamp_overcur  = n.timing ? q.flash : n.oc_latch;   // [R16]
         n.lamp_overtemp = n.ot_latch;
      end

      // ========================================================
      // Bus: write lands in the data phase, read data is
      // registered at the end of the address phase
      n.hreadyout = 1'b1;
      if (q.wr_pend) begin
         case (q.wr_addr)
            `RMSC_CTRL_OFS: begin
               n.ctrl = hwdata[2:0];               // [R20]
            end
            `RMSC_STARTUP_OFS: begin
               n.startup = hwdata[5:0];
            end
            `RMSC_TRIP_OFS: begin
               n.trip = hwdata[5:0];
            end
            `RMSC_THRESH_OFS: begin
               n.thresh = hwdata[7:0];             // [R04]
            end
            default: begin
               n.thresh = q.thresh;
            end
         endcase
      end
      addr_ok   = (haddr[31:8] == 24'h000000);
      rd_take   = hsel & htrans[1] & hready & ~hwrite;
      n.wr_pend = hsel & htrans[1] & hready & hwrite & addr_ok;
      n.wr_addr = haddr[7:0];
      if (rd_take) begin
         n.hrdata = addr_ok ? rmsc_read(n, haddr[7:0], current_over)
                            : 32'h0000_0000;
      end
   end

   // ============================================================
   // Registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q           <= '0;
         q.state     <= RMSC_IDLE;
         q.off_cnt   <= 23'h7FFFFF;
         // A command held through power-up must drop before it can start
         q.cw_q      <= 1'b1;                       // [R06]
         q.ccw_q     <= 1'b1;                       // [R06]
         q.ctrl      <= `RMSC_CTRL_RST;
         q.startup   <= `RMSC_DLY_RST;
         q.trip      <= `RMSC_DLY_RST;
         q.thresh    <= `RMSC_THRESH_RST;
         q.hreadyout <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // ============================================================
   // Outputs
   assign hrdata              = q.hrdata;
   assign hreadyout           = q.hreadyout;
   assign hresp               = 1'b0;
   assign sw_straight         = q.sw_straight;
   assign sw_swap             = q.sw_swap;
   assign sw_third            = q.sw_third;
   assign range_select_bridge = q.ctrl[`RMSC_CTRL_RANGE];   // [R20]
   assign threshold_level     = q.thresh;
   assign relay_enable        = q.relay_enable;
   assign lamp_power          = q.lamp_power;
   assign lamp_cw             = q.lamp_cw;
   assign lamp_ccw            = q.lamp_ccw;
   assign lamp_overcur        = q.lamp_overcur;
   assign lamp_overtemp       = q.lamp_overtemp;

endmodule : rmsc_top
`default_nettype wire

// ---- rmsc_top_asserts.sv ----
// Concurrent checks on the drive outputs of the reversing motor switch control.
// Assumes it is bound to rmsc_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module rmsc_top_asserts (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Commands and sensing
   input wire logic cmd_cw,
   input wire logic cmd_ccw,
   input wire logic overtemp,
   // Drive outputs
   input wire logic sw_straight,
   input wire logic sw_swap,
   input wire logic sw_third,
   input wire logic relay_enable,
   input wire logic lamp_power,
   input wire logic lamp_cw,
   input wire logic lamp_ccw
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ============================================================
   // Properties
   property p_interlock;  !(sw_straight && sw_swap); endproperty
   property p_third;  sw_third == (sw_straight || sw_swap); endproperty
   property p_edge_start;
      $rose(sw_straight) |-> cmd_cw && $past(cmd_cw);
   endproperty
   property p_release;  !cmd_cw && sw_straight |-> ##[1:2] !sw_straight; endproperty
   property p_dead;  $fell(sw_straight) |-> !sw_swap [*8]; endproperty
   property p_lamps;  lamp_cw == sw_straight && lamp_ccw == sw_swap; endproperty
   property p_overtemp;
      overtemp |-> ##[1:2] !sw_straight && !sw_swap && !relay_enable;
   endproperty
   property p_ot_latch;
      $fell(overtemp) |-> !relay_enable && !sw_straight && !sw_swap;
   endproperty
   property p_power;  (!sw_straight && !sw_swap) [*3] |-> lamp_power; endproperty

   // ============================================================
   // Assertions
   a_interlock: assert property (p_interlock)
      else $error("both switch sets driven");
   a_third: assert property (p_third)
      else $error("third phase does not follow drive");
   a_edge_start: assert property (p_edge_start)
      else $error("clockwise drive without command");
   a_release: assert property (p_release)
      else $error("clockwise drive not released");
   a_dead: assert property (p_dead)
      else $error("reversal inside dead time");
   a_lamps: assert property (p_lamps)
      else $error("direction lamp differs from drive");
   a_overtemp: assert property (p_overtemp)
      else $error("overtemperature did not stop drive");
   a_ot_latch: assert property (p_ot_latch)
      else $error("overtemperature not latched");
   a_power: assert property (p_power)
      else $error("power lamp not steady while idle");

   c_cw: cover property ($rose(sw_straight));
   c_ccw: cover property ($rose(sw_swap));
   c_trip: cover property ($fell(relay_enable));
endmodule : rmsc_top_asserts

bind rmsc_top rmsc_top_asserts chk_u (.hclk(hclk), .hresetn(hresetn), .cmd_cw(cmd_cw),
   .cmd_ccw(cmd_ccw), .overtemp(overtemp), .sw_straight(sw_straight), .sw_swap(sw_swap),
   .sw_third(sw_third), .relay_enable(relay_enable), .lamp_power(lamp_power),
   .lamp_cw(lamp_cw), .lamp_ccw(lamp_ccw));

`default_nettype wire

// ---- rmsc_plc.sv ----
// Controller model driving the two direction command inputs.
// Assumes the bench sets its requests just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module rmsc_plc (
   // Clock
   input wire logic  hclk,
   // Bench requests
   input wire logic  slow,
   input wire logic  want_cw,
   input wire logic  want_ccw,
   // Direction commands
   output var logic  cmd_cw = 1'h0,
   output var logic  cmd_ccw = 1'h0
);
   logic [1:0] lag = 2'h0;

   // Requests pass one cycle late, two with slow set; both at once only when the bench asks for it
   always @(posedge hclk) begin
      lag <= {want_ccw, want_cw};
      cmd_cw <= slow ? lag[0] : want_cw;
      cmd_ccw <= slow ? lag[1] : want_ccw;
   end
endmodule : rmsc_plc

`default_nettype wire

// ---- reversing_motor_switch_control_tb.sv ----
// Self-checking bench of the reversing motor switch control.
// Assumes rmsc_top with shortened counts and the controller model rmsc_plc.
`timescale 1ns/10ps
`default_nettype none
`include "rmsc_regs.svh"

module reversing_motor_switch_control_tb;
   logic        hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, hsel = 1'h0, sel_on = 1'h1;
   logic [2:0]  hsize = 3'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0]  htrans = 2'h0;
   logic        want_cw = 1'h0, want_ccw = 1'h0, slow = 1'h0;
   logic        cur_over = 1'h0, cur_pres = 1'h0, overtemp = 1'h0;
   logic        hreadyout, hresp, cmd_cw, cmd_ccw, sw_straight, sw_swap, sw_third;
   logic        range_sel, relay_enable, lamp_power, lamp_cw, lamp_ccw;
   logic        lamp_overcur, lamp_overtemp;
   logic [7:0]  thr;
   int          num_errors = 0, total_checks = 0, cycles = 0, n;
   int          lo_p = 0, hi_oc = 0, hi_ot = 0, lo_ot = 0;

   rmsc_top #(.TICK_CYC(20), .DEAD_S_CYC(10), .DEAD_L_CYC(30), .FLASH_CYC(4),
      .SETTLE_CYC(5)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .cmd_cw(cmd_cw), .cmd_ccw(cmd_ccw), .current_over(cur_over),
      .current_present(cur_pres), .overtemp(overtemp), .sw_straight(sw_straight),
      .sw_swap(sw_swap), .sw_third(sw_third), .range_select_bridge(range_sel),
      .threshold_level(thr), .relay_enable(relay_enable), .lamp_power(lamp_power),
      .lamp_cw(lamp_cw), .lamp_ccw(lamp_ccw), .lamp_overcur(lamp_overcur),
      .lamp_overtemp(lamp_overtemp));
   rmsc_plc plc_u (.hclk(hclk), .slow(slow), .want_cw(want_cw), .want_ccw(want_ccw),
      .cmd_cw(cmd_cw), .cmd_ccw(cmd_ccw));

   always #20 hclk = ~hclk;

   // Lamp activity counters and hang guard
   always @(posedge hclk) begin
      lo_p = lo_p + (lamp_power === 1'h0);
      hi_oc = hi_oc + (lamp_overcur === 1'h1);
      hi_ot = hi_ot + (lamp_overtemp === 1'h1);
      lo_ot = lo_ot + (lamp_overtemp === 1'h0);
      cycles = cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         conclude();
      end
   end

   // ============================================================
   // Shared tasks
   task cyc(input int k); repeat (k) @(posedge hclk); endtask : cyc
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      hsel <= sel_on;
      hsize <= 3'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask : bus
   task setup(input logic [31:0] c);
      bus(1'h1, `RMSC_CTRL_OFS, c);
      bus(1'h1, `RMSC_STARTUP_OFS, 32'h1);
      bus(1'h1, `RMSC_TRIP_OFS, 32'h1);
   endtask : setup
   task do_reset;
      hresetn <= 1'h0;
      cyc(5);
      hresetn <= 1'h1;
      cyc(2);
   endtask : do_reset
   task conclude;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   // ============================================================
   // Scenarios
   task t_regs;
      chk("relay", relay_enable, 1'h1);
      chk("power lamp", lamp_power, 1'h1);
      chk("threshold", thr, 8'h80);
      sel_on = 1'h0;
      bus(1'h1, `RMSC_THRESH_OFS, 32'h55);
      sel_on = 1'h1;
      cyc(1);
      chk("deselected", thr, 8'h80);
      chk("response", hresp, 1'h0);
      bus(1'h0, `RMSC_STARTUP_OFS, 32'h0);
      chk("startup", q, 32'h0A);
      bus(1'h0, 8'h20, 32'h0);
      chk("unmapped", q, 32'h0);
      bus(1'h1, `RMSC_THRESH_OFS, 32'h33);
      bus(1'h1, `RMSC_CTRL_OFS, 32'h4);
      cyc(1);
      chk("threshold", thr, 8'h33);
      chk("range", range_sel, 1'h1);
      $display("test regs done");
   endtask : t_regs
   task t_start;
      setup(32'h0);
      want_cw <= 1'h1;
      cyc(3);
      chk("cw on", sw_straight, 1'h1);
      chk("third", sw_third, 1'h1);
      chk("cw lamp", lamp_cw, 1'h1);
      lo_p = 0;
      cyc(12);
      chk("power flash", lo_p != 0, 1'h1);
      cyc(15);
      want_ccw <= 1'h1;
      cyc(3);
      chk("blocked", {sw_straight, sw_swap}, 2'h2);
      want_cw <= 1'h0;
      want_ccw <= 1'h0;
      cyc(3);
      chk("released", sw_straight, 1'h0);
      $display("test start done");
   endtask : t_start
   task t_rev(input logic [31:0] c, input int dl);
      setup(c);
      want_cw <= 1'h1;
      cyc(30);
      want_cw <= 1'h0;
      want_ccw <= 1'h1;
      while (sw_straight !== 1'h0) cyc(1);
      n = 0;
      while (sw_swap !== 1'h1 && n < 100) begin
         cyc(1);
         n++;
      end
      chk("dead time", n >= dl - 1 && n <= dl + 3, 1'h1);
      chk("ccw lamp", lamp_ccw, 1'h1);
      cyc(25);
      want_ccw <= 1'h0;
      cyc(3);
      $display("test reversal done");
   endtask : t_rev
   task t_oc_start;
      setup(32'h0);
      slow <= 1'h1;
      cur_over <= 1'h1;
      want_cw <= 1'h1;
      cyc(8);
      chk("blanked", relay_enable, 1'h1);
      cyc(25);
      chk("start trip", relay_enable, 1'h0);
      chk("still on", sw_straight, 1'h1);
      want_cw <= 1'h0;
      cur_over <= 1'h0;
      cyc(4);
      chk("cleared", relay_enable, 1'h1);
      slow <= 1'h0;
      $display("test start-up trip done");
   endtask : t_oc_start
   task t_trip;
      setup(32'h1);
      want_cw <= 1'h1;
      cyc(30);
      hi_oc = 0;
      cur_over <= 1'h1;
      cyc(8);
      cur_over <= 1'h0;
      cyc(30);
      chk("cancelled", relay_enable, 1'h1);
      chk("oc flash", hi_oc != 0, 1'h1);
      cur_over <= 1'h1;
      cyc(10);
      chk("delaying", relay_enable, 1'h1);
      cyc(16);
      chk("tripped", relay_enable, 1'h0);
      chk("motor off", sw_straight, 1'h0);
      want_cw <= 1'h0;
      cur_over <= 1'h0;
      cyc(4);
      chk("cleared", relay_enable, 1'h1);
      $display("test switching delay done");
   endtask : t_trip
   task t_ot;
      setup(32'h0);
      want_cw <= 1'h1;
      cyc(30);
      overtemp <= 1'h1;
      cyc(2);
      overtemp <= 1'h0;
      cyc(3);
      chk("ot state", {sw_straight, relay_enable, lamp_overtemp}, 3'h1);
      want_cw <= 1'h0;
      cyc(3);
      want_cw <= 1'h1;
      cyc(4);
      chk("ot held", {sw_straight, relay_enable}, 2'h0);
      want_cw <= 1'h0;
      do_reset();
      chk("ot reset", relay_enable, 1'h1);
      $display("test overtemperature done");
   endtask : t_ot
   task t_sys;
      cur_pres <= 1'h1;
      cyc(10);
      cur_pres <= 1'h0;
      hi_ot = 0;
      lo_ot = 0;
      want_cw <= 1'h1;
      cyc(16);
      chk("refused", sw_straight, 1'h0);
      chk("red flash", hi_ot != 0 && lo_ot != 0, 1'h1);
      do_reset();
      setup(32'h0);
      chk("held level", sw_straight, 1'h0);
      want_cw <= 1'h0;
      cyc(2);
      want_cw <= 1'h1;
      cyc(30);
      chk("new edge", sw_straight, 1'h1);
      want_cw <= 1'h0;
      cyc(3);
      $display("test system fault done");
   endtask : t_sys

   initial begin
      cyc(5);
      hresetn <= 1'h1;
      cyc(2);
      t_regs();
      t_start();
      t_rev(32'h0, 10);
      t_rev(32'h2, 30);
      t_oc_start();
      t_trip();
      t_ot();
      t_sys();
      conclude();
   end
endmodule : reversing_motor_switch_control_tb

`default_nettype wire
